/* File: pcal_alert_monitor.sv */
// Port-level checker for the change alert block.
// Assumes it is bound to pcal_alert_top.
`timescale 1ns/10ps
module pcal_alert_monitor (
  // Clocks and resets.
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic link_rst_b,
  // Watched ports.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pcal_pkg::pcal_addr_t paddr,
  input wire pcal_pkg::pcal_data_t pwdata,
  input wire pcal_pkg::pcal_data_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pcal_pkg::pcal_ports_t link_port_read_ack,
  input wire pcal_pkg::pcal_pins_t gpio_level,
  input wire logic alert_pin_data,
  input wire logic alert_pin_oe
);
  import pcal_pkg::*;
  pcal_pins_t gpio_q;
  logic [3:0] age_q;
  logic [3:0] age_d;
  // Any legal cause of an alert change restarts the age, so a move with no cause is caught.
  always_comb begin
    age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
    if (gpio_level != gpio_q || link_port_read_ack != 2'h0 || (psel && pwrite)) age_d = 4'h0;
  end
  always_ff @(posedge core_clk) begin
    gpio_q <= gpio_level;
    age_q <= rst_b ? age_d : 4'h0;
  end
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_mask_all;
    psel && penable && pwrite && paddr == 8'h00 && pwdata[15:0] == 16'hFFFF;
  endsequence
  property p_od;
    @(posedge core_clk) disable iff (!rst_b) alert_pin_data == 1'b0;
  endproperty
  property p_rdy;
    @(posedge core_clk) disable iff (!rst_b) s_acc |-> pready;
  endproperty
  property p_err;
    @(posedge core_clk) disable iff (!rst_b) s_acc |-> pslverr == !(paddr <= 8'h18 && paddr[1:0] == 2'b00);
  endproperty
  property p_hi;
    @(posedge core_clk) disable iff (!rst_b) s_acc ##0 !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  property p_rst;
    @(posedge core_clk) !rst_b ##1 rst_b |-> !alert_pin_oe [*4];
  endproperty
  property p_mask;
    @(posedge core_clk) disable iff (!rst_b) s_mask_all |-> ##[1:2] !alert_pin_oe;
  endproperty
  property p_rise;
    @(posedge core_clk) disable iff (!rst_b) $rose(alert_pin_oe) |-> age_q <= 4'h8;
  endproperty
  property p_fall;
    @(posedge core_clk) disable iff (!rst_b) $fell(alert_pin_oe) |-> age_q <= 4'h9;
  endproperty
  a_od: assert property (p_od) else $error("alert data not low");
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  a_hi: assert property (p_hi) else $error("upper read bits not zero");
  a_rst: assert property (p_rst) else $error("alert after reset");
  a_mask: assert property (p_mask) else $error("alert kept with all masked");
  a_rise: assert property (p_rise) else $error("alert raised without cause");
  a_fall: assert property (p_fall) else $error("alert cleared without cause");
endmodule
bind pcal_alert_top pcal_alert_monitor pcal_alert_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
  .link_clk(link_clk), .link_rst_b(link_rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_port_read_ack(link_port_read_ack), .gpio_level(gpio_level), .alert_pin_data(alert_pin_data),
  .alert_pin_oe(alert_pin_oe));

/* File: pcal_alert_top.sv */
// Port change detection and open-drain alert for a 16-pin, two-port expander.
// Assumes an APB master on core_clk and a serial slave that pulses a port-read
// strobe on link_clk at the acknowledge bit of each input-port read.
//
// Notes on behaviour
// - Alert pin active low, open drain only.
// - Any edge on an input pin alerts.
// - Return to old level or port read clears.
// - Output pins never raise an alert.
// - Output-to-input switch may alert at once.
// - Held pins clear only on port read.
// - Read clear taken at acknowledge bit.
// - Mask bit one blocks the alert.
// - Unmasking pending change alerts; masking source releases.
// - All mask bits reset to one.
// - Source flags show unmasked pending pins only.
`timescale 1ns/10ps
`include "pcal_defines.svh"

module pcal_alert_top (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pcal_pkg::pcal_addr_t paddr,
  input wire pcal_pkg::pcal_data_t pwdata,
  output pcal_pkg::pcal_data_t prdata,
  output logic pready,
  output logic pslverr,
  // Serial link side.
  input wire logic link_clk,
  input wire logic link_rst_b,
  input wire pcal_pkg::pcal_ports_t link_port_read_ack,
  // Port pins.
  input wire pcal_pkg::pcal_pins_t gpio_level,
  // Alert pin.
  output logic alert_pin_data,
  output logic alert_pin_oe
);
  import pcal_pkg::*;

  pcal_pins_t live;
  pcal_ports_t rd_evt;
  pcal_pins_t rd_pin;

  pcal_pins_t mask_q;
  pcal_pins_t mask_d;
  pcal_pins_t hold_q;
  pcal_pins_t hold_d;
  pcal_pins_t dir_q;
  pcal_pins_t dir_d;
  pcal_data_t prdata_q;
  pcal_data_t prdata_d;

  pcal_pins_t ref_q;
  pcal_pins_t ref_d;
  pcal_pins_t lat_q;
  pcal_pins_t lat_d;
  pcal_pins_t cap_q;
  pcal_pins_t cap_d;
  logic [2:0] seed_cnt_q;
  logic [2:0] seed_cnt_d;
  logic seeding;
  logic alert_q;
  logic alert_d;

  pcal_pins_t pend;
  pcal_pins_t source;
  logic setup_ph;
  logic access_ph;
  logic mapped;

  function automatic logic reg_hit(input pcal_addr_t addr, input pcal_addr_t ofs);
    reg_hit = (addr == ofs);
  endfunction

  function automatic logic reg_known(input pcal_addr_t addr);
    reg_known = reg_hit(addr, `PCAL_OFS_MASK) || reg_hit(addr, `PCAL_OFS_HOLD) ||
                reg_hit(addr, `PCAL_OFS_DIR) || reg_hit(addr, `PCAL_OFS_SOURCE) ||
                reg_hit(addr, `PCAL_OFS_REF) || reg_hit(addr, `PCAL_OFS_LIVE) ||
                reg_hit(addr, `PCAL_OFS_STATUS);
  endfunction

  // Pin levels come from outside any clock domain.
  pcal_sync2 #(.W(`PCAL_PINS)) u_pin_sync (
    .clk(core_clk),
    .rst_b(rst_b),
    .async_in(gpio_level),
    .sync_out(live)
  );

  // The read strobe lands a few core cycles after the acknowledge bit.
  pcal_pulse_xing #(.W(`PCAL_PORTS)) u_read_xing (
    .src_clk(link_clk),
    .src_rst_b(link_rst_b),
    .src_pulse(link_port_read_ack),
    .dst_clk(core_clk),
    .dst_rst_b(rst_b),
    .dst_pulse(rd_evt)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `PCAL_PINS; gi++) begin : g_rd
      assign rd_pin[gi] = rd_evt[gi / `PCAL_PORT_W];
    end
  endgenerate

  // Register bus: zero wait states, unmapped addresses answer with an error.
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped = reg_known(paddr);
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = prdata_q;

  always_comb begin
    mask_d = mask_q;
    hold_d = hold_q;
    dir_d = dir_q;
    prdata_d = prdata_q;
    if (access_ph && pwrite) begin
      if (reg_hit(paddr, `PCAL_OFS_MASK)) begin
        mask_d = pwdata[`PCAL_PINS-1:0];
      end
      if (reg_hit(paddr, `PCAL_OFS_HOLD)) begin
        hold_d = pwdata[`PCAL_PINS-1:0];
      end
      if (reg_hit(paddr, `PCAL_OFS_DIR)) begin
        dir_d = pwdata[`PCAL_PINS-1:0];
      end
    end
    if (setup_ph && !pwrite) begin
      prdata_d = '0;
      if (reg_hit(paddr, `PCAL_OFS_MASK)) begin
        prdata_d[`PCAL_PINS-1:0] = mask_q;
      end
      if (reg_hit(paddr, `PCAL_OFS_HOLD)) begin
        prdata_d[`PCAL_PINS-1:0] = hold_q;
      end
      if (reg_hit(paddr, `PCAL_OFS_DIR)) begin
        prdata_d[`PCAL_PINS-1:0] = dir_q;
      end
      if (reg_hit(paddr, `PCAL_OFS_SOURCE)) begin
        prdata_d[`PCAL_PINS-1:0] = source;
      end
      if (reg_hit(paddr, `PCAL_OFS_REF)) begin
        prdata_d[`PCAL_PINS-1:0] = ref_q;
      end
      // Held pins read back the captured level until their port is read.
      if (reg_hit(paddr, `PCAL_OFS_LIVE)) begin
        prdata_d[`PCAL_PINS-1:0] = (lat_q & cap_q) | (~lat_q & live);
      end
      if (reg_hit(paddr, `PCAL_OFS_STATUS)) begin
        prdata_d[0] = alert_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mask_q <= `PCAL_RST_MASK;
      hold_q <= `PCAL_RST_HOLD;
      dir_q <= `PCAL_RST_DIR;
      prdata_q <= '0;
    end else begin
      mask_q <= mask_d;
      hold_q <= hold_d;
      dir_q <= dir_d;
      prdata_q <= prdata_d;
    end
  end

  // Change detection. The reference follows the pins until the synchroniser
  // has refilled after reset, so idle levels at start-up are not changes.
  assign seeding = (seed_cnt_q != `PCAL_SEED_CYCLES);

  always_comb begin
    ref_d = ref_q;
    lat_d = lat_q;
    cap_d = cap_q;
    seed_cnt_d = seed_cnt_q;
    alert_d = !seeding && (|source);
    if (seeding) begin
      ref_d = live;
      seed_cnt_d = 3'(seed_cnt_q + 3'h1);
    end else begin
      for (int i = 0; i < `PCAL_PINS; i++) begin
        if (rd_pin[i] && dir_q[i]) begin
          ref_d[i] = live[i];
          lat_d[i] = 1'b0;
        end else if (!hold_q[i]) begin
          // A stale capture must not come back when holding is enabled again.
          lat_d[i] = 1'b0;
        end else if (dir_q[i] && !lat_q[i] && (live[i] != ref_q[i])) begin
          lat_d[i] = 1'b1;
          cap_d[i] = live[i];
        end
      end
    end
  end

  // Output pins keep a stale reference, so turning one back into an input
  // alerts at once if the pin moved meanwhile.
  assign pend = dir_q & ((~hold_q & (live ^ ref_q)) | (hold_q & lat_q));
  assign source = pend & ~mask_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ref_q <= `PCAL_RST_REF;
      lat_q <= '0;
      cap_q <= '0;
      seed_cnt_q <= 3'h0;
      alert_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      lat_q <= lat_d;
      cap_q <= cap_d;
      seed_cnt_q <= seed_cnt_d;
      alert_q <= alert_d;
    end
  end

  // Open drain: only ever drive low, release otherwise.
  assign alert_pin_data = 1'b0;
  assign alert_pin_oe = alert_q;
endmodule

/* File: pcal_alert_top_test.sv */
// Bench for the change alert block: APB tasks, pin stimulus and link read frames.
// Assumes pcal_link_host stands in for the serial master.
`timescale 1ns/10ps
module pcal_alert_top_test;
  import pcal_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic req = 1'b0;
  logic pready, pslverr, link_clk, alert_pin_data, alert_pin_oe;
  pcal_addr_t paddr = 8'h00;
  pcal_data_t pwdata = 32'h00000000;
  pcal_data_t prdata;
  pcal_ports_t sel = 2'h0;
  pcal_ports_t ack;
  pcal_pins_t gpio = 16'h0000;
  int n_errors = 0;
  int tests_run = 0;
  always #20 core_clk = ~core_clk;
  pcal_alert_top pcal_alert_top_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_rst_b(rst_b), .link_port_read_ack(ack), .gpio_level(gpio),
    .alert_pin_data(alert_pin_data), .alert_pin_oe(alert_pin_oe));
  pcal_link_host pcal_link_host_i (.req(req), .port_sel(sel), .link_clk(link_clk), .link_port_read_ack(ack));
  task automatic tally_and_finish;
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input pcal_data_t got, input pcal_data_t exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // The pin is looked at mid-cycle, once the alert flop has settled.
  task automatic lv(input logic exp);
    @(negedge core_clk);
    tests_run++;
    if (alert_pin_oe !== exp || alert_pin_data !== 1'b0) begin
      n_errors++;
      $display("CHECK FAILED at %0t: alert pin wrong", $time);
    end
    @(posedge core_clk);
  endtask
  task automatic apb(input logic wr, input pcal_addr_t a, input pcal_data_t d, output pcal_data_t r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input pcal_addr_t a, input pcal_data_t exp, input logic exp_e);
    pcal_data_t r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp);
    chk({31'h00000000, e}, {31'h00000000, exp_e});
  endtask
  task automatic wr(input pcal_addr_t a, input pcal_data_t d);
    pcal_data_t r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic pin(input pcal_pins_t v, input logic exp);
    gpio <= v;
    repeat (8) @(posedge core_clk);
    lv(exp);
  endtask
  task automatic link(input pcal_ports_t s);
    sel <= s;
    req <= 1'b1;
    repeat (16) @(posedge core_clk);
    req <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    @(posedge core_clk);
    req <= 1'b1;
    repeat (11) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    req <= 1'b0;
    rd(8'h00, 32'h0000FFFF, 1'b0);
    rd(8'h04, 32'h00000000, 1'b0);
    rd(8'h08, 32'h0000FFFF, 1'b0);
    rd(8'h1C, 32'h00000000, 1'b1);
    pin(16'h0008, 1'b0);
    rd(8'h0C, 32'h00000000, 1'b0);
    wr(8'h00, 32'h00000000);
    lv(1'b1);
    rd(8'h0C, 32'h00000008, 1'b0);
    pin(16'h0000, 1'b0);
    pin(16'h0200, 1'b1);
    wr(8'h00, 32'h0000FFFF);
    lv(1'b0);
    rd(8'h0C, 32'h00000000, 1'b0);
    wr(8'h00, 32'h00000000);
    lv(1'b1);
    link(2'h2);
    lv(1'b0);
    rd(8'h10, 32'h00000200, 1'b0);
    wr(8'h08, 32'h0000FFFE);
    pin(16'h0201, 1'b0);
    wr(8'h08, 32'h0000FFFF);
    lv(1'b1);
    link(2'h1);
    lv(1'b0);
    wr(8'h04, 32'h00000010);
    pin(16'h0211, 1'b1);
    pin(16'h0201, 1'b1);
    rd(8'h0C, 32'h00000010, 1'b0);
    rd(8'h14, 32'h00000211, 1'b0);
    rd(8'h18, 32'h00000001, 1'b0);
    link(2'h1);
    lv(1'b0);
    rd(8'h14, 32'h00000201, 1'b0);
    rd(8'h18, 32'h00000000, 1'b0);
    // Reset in mid-run; a link frame runs meanwhile so the link side clears too.
    rst_b <= 1'b0;
    sel <= 2'h0;
    req <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    req <= 1'b0;
    rd(8'h00, 32'h0000FFFF, 1'b0);
    rd(8'h10, 32'h00000201, 1'b0);
    lv(1'b0);
    tally_and_finish;
  end
endmodule

/* File: pcal_defines.svh */
// Register offsets, reset values and widths of the port change alert logic.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PCAL_DEFINES_SVH
`define PCAL_DEFINES_SVH

`define PCAL_PINS 16
`define PCAL_PORT_W 8
`define PCAL_PORTS 2
`define PCAL_ADDR_W 8
`define PCAL_DATA_W 32

`define PCAL_OFS_MASK 8'h00
`define PCAL_OFS_HOLD 8'h04
`define PCAL_OFS_DIR 8'h08
`define PCAL_OFS_SOURCE 8'h0C
`define PCAL_OFS_REF 8'h10
`define PCAL_OFS_LIVE 8'h14
`define PCAL_OFS_STATUS 8'h18

`define PCAL_RST_MASK 16'hFFFF
`define PCAL_RST_HOLD 16'h0000
`define PCAL_RST_DIR 16'hFFFF
`define PCAL_RST_REF 16'h0000

`define PCAL_SYNC_STAGES 2
`define PCAL_SEED_CYCLES 3'h3

`endif

/* File: pcal_link_host.sv */
// Serial bus master model: runs one link clock frame per request.
// Assumes requests are spaced wider than one frame.
`timescale 1ns/10ps
module pcal_link_host (
  // Frame request.
  input wire logic req,
  input wire pcal_pkg::pcal_ports_t port_sel,
  // Link side.
  output logic link_clk,
  output pcal_pkg::pcal_ports_t link_port_read_ack
);
  import pcal_pkg::*;
  initial begin
    link_clk = 1'b0;
    link_port_read_ack = 2'h0;
  end
  // The clock stands low between frames, as a serial clock does.
  always @(posedge req) begin
    #7;
    for (int i = 0; i < 6; i++) begin
      link_clk = 1'b1;
      link_port_read_ack <= (i == 2) ? port_sel : 2'h0;
      #40;
      link_clk = 1'b0;
      #40;
    end
  end
endmodule

/* File: pcal_pkg.sv */
// Shared types of the port change alert logic.
// Assumes pcal_defines.svh is on the include path.
`include "pcal_defines.svh"

package pcal_pkg;
  typedef logic [`PCAL_PINS-1:0] pcal_pins_t;
  typedef logic [`PCAL_PORTS-1:0] pcal_ports_t;
  typedef logic [`PCAL_ADDR_W-1:0] pcal_addr_t;
  typedef logic [`PCAL_DATA_W-1:0] pcal_data_t;
endpackage

/* File: pcal_pulse_xing.sv */
// Carries one-cycle pulses from a source clock to a destination clock by toggles.
// Assumes source pulses on one bit are at least three destination cycles apart.
`timescale 1ns/10ps

module pcal_pulse_xing #(
  parameter int W = 2
) (
  // Source side.
  input wire logic src_clk,
  input wire logic src_rst_b,
  input wire logic [W-1:0] src_pulse,
  // Destination side.
  input wire logic dst_clk,
  input wire logic dst_rst_b,
  output logic [W-1:0] dst_pulse
);
  logic [W-1:0] tog_q;
  logic [W-1:0] tog_d;
  logic [W-1:0] tog_sync;
  logic [W-1:0] seen_q;
  logic [W-1:0] seen_d;

  // A toggle survives a stopped source clock, unlike a stretched pulse.
  always_comb begin
    tog_d = tog_q ^ src_pulse;
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_b) begin
      tog_q <= '0;
    end else begin
      tog_q <= tog_d;
    end
  end

  pcal_sync2 #(.W(W)) u_sync (
    .clk(dst_clk),
    .rst_b(dst_rst_b),
    .async_in(tog_q),
    .sync_out(tog_sync)
  );

  always_comb begin
    seen_d = tog_sync;
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_b) begin
      seen_q <= '0;
    end else begin
      seen_q <= seen_d;
    end
  end

  assign dst_pulse = tog_sync ^ seen_q;
endmodule

/* File: pcal_sync2.sv */
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level that may change at any time relative to clk.
`timescale 1ns/10ps

module pcal_sync2 #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Levels.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
